// file: can_status_pkg.sv
// constants, register map and carrier types of the can status and error block
package can_status_pkg;
  // ==========================================================
  // register offsets (byte addresses on the avalon slave)
  localparam logic [5:0] OFS_TX_PRIO = 6'h00;
  localparam logic [5:0] OFS_FIFO0 = 6'h04;
  localparam logic [5:0] OFS_FIFO1 = 6'h08;
  localparam logic [5:0] OFS_IRQ_EN = 6'h0C;
  localparam logic [5:0] OFS_ERR_STAT = 6'h10;
  localparam logic [5:0] OFS_ERR_IRQ_EN = 6'h14;
  localparam logic [5:0] OFS_TX_ERR = 6'h18;
  localparam logic [5:0] OFS_RX_ERR = 6'h1C;
  localparam logic [5:0] OFS_DIAG = 6'h20;
  localparam logic [5:0] OFS_BT_PRESCALE = 6'h24;
  localparam logic [5:0] OFS_BT_SEGMENTS = 6'h28;
  localparam logic [5:0] OFS_MASTER_STAT = 6'h2C;
  localparam logic [5:0] OFS_TX_STAT = 6'h30;
  // ==========================================================
  // field positions
  localparam int FIFO_RELEASE_BIT = 5;
  localparam int FIFO_OVR_BIT = 4;
  localparam int FIFO_FULL_BIT = 3;
  localparam int ESR_BUS_OFF_FLAG_BIT = 2;
  localparam int ESR_EPV_BIT = 1;
  localparam int ESR_EWG_BIT = 0;
  localparam int MSR_WAKE_BIT = 3;
  localparam int MSR_ERROR_IRQ_FLAG_BIT = 2;
  localparam int DIAG_LISTEN_BIT = 1;
  localparam int DIAG_LOOP_BIT = 0;
  // ==========================================================
  // reset values and limits
  localparam logic [7:0] BT_SEGMENTS_RESET = 8'h23;
  localparam logic [2:0] LEC_NONE = 3'h0;
  localparam logic [1:0] FIFO_DEPTH = 2'h3;
  localparam logic [8:0] WARN_LIMIT = 9'h060;
  localparam logic [8:0] PASSIVE_LIMIT = 9'h07F;
  localparam logic [8:0] REC_HIGH_LIMIT = 9'h080;
  localparam logic [8:0] REC_RESTART = 9'h078;
  localparam logic [8:0] ERR_STEP_BIG = 9'h008;
  localparam logic [8:0] ERR_STEP_ONE = 9'h001;
  localparam logic [8:0] TEC_SATURATE = 9'h1FF;
  // ==========================================================
  // events from the protocol engine, one-cycle pulses unless noted
  typedef struct packed {
    logic [2:0] tx_done;      // mailbox request finished
    logic [1:0] rx_store;     // message passed filtering into fifo n
    logic sof_seen;           // start of frame seen on the bus
    logic err_valid;          // bus error detected
    logic [2:0] err_code;     // error type with err_valid
    logic frame_ok;           // frame sent or received cleanly
    logic tec_inc8;           // transmit error, +8
    logic tec_dec;            // successful transmission, -1
    logic rec_inc1;           // receive error, +1
    logic rec_inc8;           // receive error, +8
    logic rec_ok;             // successful reception
    logic bus_off_recover;    // bus-off recovery done, counters cleared
  } core_events_t;
  // bit timing handed to the bit engine
  typedef struct packed {
    logic [1:0] resync_jump_width;
    logic [5:0] quantum_prescaler;
    logic [2:0] seg2;
    logic [3:0] seg1;
  } bit_timing_t;
endpackage

// file: can_status_error_interrupt.sv
// status, interrupt enable, error confinement, diagnosis and bit timing registers
// Summary of operation
// - code gives next free, else lowest-priority mailbox
// - mailbox zero empty flag when nothing pending
// - release frees output box only if pending
// - store into full fifo sets overrun flag
// - full flag set at three stored messages
// - pending count up on store, down on release
// - wake-up flag interrupts when its enable set
// - per-fifo enables gate overrun and full interrupts
// - per-fifo enable gates interrupt while pending count nonzero
// - request-completed flag interrupts when enable set
// - last error code records latest bus error type
// - clean frame clears code; software may write seven
// - bus-off flag when transmit counter exceeds 255
// - error-passive flag when a counter exceeds 127
// - error-warning flag when a counter exceeds 96
// - error interrupt while enabled error flag pending
// - enables choose which error events set flag
// - transmit counter nine bits, low byte readable
// - receive counter up 1/8, down 1, or 120
// - diagnosis shows live rx pin and sample
// - silent and loop-back mode selects
// - prescale register writable only in configuration mode
// - error flag set on enabled error status event
// - wake-up flag set by start of frame asleep
// - request-completed flag set by hardware, software clears
//
// Chosen here: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/100ps
`default_nettype none
module can_status_error_interrupt
  import can_status_pkg::*;
#(
  parameter int MAILBOXES = 3
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // avalon-mm slave
  input wire logic [5:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  // protocol engine side
  input wire core_events_t events,
  input wire logic [2:0] tx_pending,
  input wire logic [1:0] tx_lowest,
  input wire logic sleep_mode,
  input wire logic config_mode,
  input wire logic sample_bit,
  input wire logic can_rx,
  // controls and interrupt lines
  output bit_timing_t bit_timing,
  output logic listen_only_sel,
  output logic loopback_sel,
  output logic [1:0] fifo_release,
  output logic status_irq,
  output logic tx_irq,
  output logic [1:0] fifo_irq
);
  initial begin
    if (MAILBOXES != 3) begin
      $error("only three transmit mailboxes are supported");
    end
  end
  // ==========================================================
  // reset release
  logic [1:0] rst_pipe; // release synchroniser
  logic rst_sync_n; // reset used by the block
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_pipe <= 2'h0;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end
  assign rst_sync_n = rst_pipe[1];
  // ==========================================================
  // bus slave: one wait cycle per access
  logic ack; // answer cycle
  logic wr_go; // write takes effect
  logic [7:0] wbyte; // low write byte
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      ack <= 1'b0;
    end else begin
      ack <= (read || write) && !ack;
    end
  end
  assign waitrequest = (read || write) && !ack;
  assign wr_go = write && ack && byteenable[0];
  assign wbyte = writedata[7:0];
  // write strobe decode
  function automatic logic hit(input logic [5:0] ofs);
    return wr_go && (address == ofs);
  endfunction
  // ==========================================================
  // rx pin synchroniser
  logic [1:0] rx_pipe; // first stage read only by second
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      rx_pipe <= 2'h3;
    end else begin
      rx_pipe <= {rx_pipe[0], can_rx};
    end
  end
  // ==========================================================
  // transmit mailbox status
  logic [2:0] tx_empty; // per-mailbox empty
  logic [1:0] tx_code; // mailbox code
  logic [2:0] request_done_flag; // request completed
  assign tx_empty = ~tx_pending;
  always_comb begin
    if (tx_empty[0]) begin
      tx_code = 2'h0;
    end else if (tx_empty[1]) begin
      tx_code = 2'h1;
    end else if (tx_empty[2]) begin
      tx_code = 2'h2;
    end else begin
      tx_code = tx_lowest;
    end
  end
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      request_done_flag <= 3'h0;
    end else if (hit(OFS_TX_STAT)) begin
      request_done_flag <= (request_done_flag & ~wbyte[2:0]) | events.tx_done;
    end else begin
      request_done_flag <= request_done_flag | events.tx_done;
    end
  end
  // ==========================================================
  // receive fifos
  logic [1:0] pending_msg_count [2]; // per-fifo count
  logic [1:0] fifo_full_flag; // sticky full
  logic [1:0] fifo_overrun_flag; // sticky overrun
  logic [1:0] release_output_box; // release in progress
  logic [7:0] interrupt_enable; // interrupt enables
  genvar f;
  generate
    for (f = 0; f < 2; f++) begin : g_fifo
      logic wr_fifo; // write to this fifo register
      logic stored; // message accepted
      logic released; // output box freed
      // procedural so the decode follows the bus signals read inside hit
      always_comb begin
        wr_fifo = hit(f == 0 ? OFS_FIFO0 : OFS_FIFO1);
      end
      // locked fifo: full store is dropped
      assign stored = events.rx_store[f] && (pending_msg_count[f] != FIFO_DEPTH);
      assign released = release_output_box[f];
      // release only with a message pending
      always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
          release_output_box[f] <= 1'b0;
        end else begin
          release_output_box[f] <= wr_fifo && wbyte[FIFO_RELEASE_BIT]
            && !released && (pending_msg_count[f] != 2'h0);
        end
      end
      // count up on store, down on release
      always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
          pending_msg_count[f] <= 2'h0;
        end else if (stored && !released) begin
          pending_msg_count[f] <= pending_msg_count[f] + 2'h1;
        end else if (released && !stored) begin
          pending_msg_count[f] <= pending_msg_count[f] - 2'h1;
        end
      end
      always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
          fifo_full_flag[f] <= 1'b0;
        end else if (stored && !released && pending_msg_count[f] == 2'h2) begin
          fifo_full_flag[f] <= 1'b1;
        end else if (wr_fifo && wbyte[FIFO_FULL_BIT]) begin
          fifo_full_flag[f] <= 1'b0;
        end
      end
      // overrun on store into full fifo
      always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
          fifo_overrun_flag[f] <= 1'b0;
        end else if (events.rx_store[f] && pending_msg_count[f] == FIFO_DEPTH) begin
          fifo_overrun_flag[f] <= 1'b1;
        end else if (wr_fifo && wbyte[FIFO_OVR_BIT]) begin
          fifo_overrun_flag[f] <= 1'b0;
        end
      end
      // fifo interrupt line, enables at 1+3f..3+3f
      assign fifo_irq[f] = (fifo_overrun_flag[f] && interrupt_enable[3 + 3 * f])
        || (fifo_full_flag[f] && interrupt_enable[2 + 3 * f])
        || ((pending_msg_count[f] != 2'h0) && interrupt_enable[1 + 3 * f]);
    end
  endgenerate
  assign fifo_release = release_output_box;
  // ==========================================================
  // enable and mode registers
  logic [7:0] error_interrupt_enable; // error event enables
  logic [1:0] diag_modes; // listen-only and loop-back
  logic [7:0] bit_timing_prescale; // prescaler and jump width
  logic [6:0] bit_timing_segments; // segment lengths
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      interrupt_enable <= 8'h00;
      error_interrupt_enable <= 8'h00;
    end else begin
      if (hit(OFS_IRQ_EN)) begin
        interrupt_enable <= wbyte;
      end
      if (hit(OFS_ERR_IRQ_EN)) begin
        error_interrupt_enable <= wbyte & 8'h97;
      end
    end
  end
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      diag_modes <= 2'h0;
    end else if (hit(OFS_DIAG)) begin
      diag_modes <= wbyte[1:0];
    end
  end
  assign listen_only_sel = diag_modes[DIAG_LISTEN_BIT];
  assign loopback_sel = diag_modes[DIAG_LOOP_BIT];
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      bit_timing_prescale <= 8'h00;
      bit_timing_segments <= BT_SEGMENTS_RESET[6:0];
    end else begin
      if (hit(OFS_BT_PRESCALE) && config_mode) begin
        bit_timing_prescale <= wbyte;
      end
      if (hit(OFS_BT_SEGMENTS)) begin
        bit_timing_segments <= wbyte[6:0];
      end
    end
  end
  assign bit_timing = {bit_timing_prescale, bit_timing_segments};
  // ==========================================================
  // error counters
  logic [8:0] tx_err_counter; // nine-bit transmit counter
  logic [8:0] rx_err_counter; // receive counter
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      tx_err_counter <= 9'h000;
    end else if (events.bus_off_recover) begin
      tx_err_counter <= 9'h000;
    end else if (events.tec_inc8) begin
      tx_err_counter <= (tx_err_counter > TEC_SATURATE - ERR_STEP_BIG) ? TEC_SATURATE
        : tx_err_counter + ERR_STEP_BIG;
    end else if (events.tec_dec && tx_err_counter != 9'h000) begin
      tx_err_counter <= tx_err_counter - ERR_STEP_ONE;
    end
  end
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      rx_err_counter <= 9'h000;
    end else if (events.bus_off_recover) begin
      rx_err_counter <= 9'h000;
    end else if (events.rec_inc8) begin
      rx_err_counter <= (rx_err_counter > TEC_SATURATE - ERR_STEP_BIG) ? TEC_SATURATE
        : rx_err_counter + ERR_STEP_BIG;
    end else if (events.rec_inc1) begin
      rx_err_counter <= (rx_err_counter == TEC_SATURATE) ? TEC_SATURATE
        : rx_err_counter + ERR_STEP_ONE;
    end else if (events.rec_ok) begin
      if (rx_err_counter > REC_HIGH_LIMIT) begin
        rx_err_counter <= REC_RESTART;
      end else if (rx_err_counter != 9'h000) begin
        rx_err_counter <= rx_err_counter - ERR_STEP_ONE;
      end
    end
  end
  // ==========================================================
  // error status
  logic bus_off_flag; // bus-off state
  logic err_passive_flag; // error passive
  logic err_warning_flag; // error warning
  logic [2:0] last_error_kind; // last error code
  logic error_irq_flag; // error interrupt flag
  logic wakeup_flag; // wake-up flag
  logic err_event; // enabled error event this cycle
  logic bus_off_prev; // bus-off flag one cycle earlier
  logic passive_prev; // error-passive flag one cycle earlier
  logic warning_prev; // error-warning flag one cycle earlier
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      bus_off_flag <= 1'b0;
      err_passive_flag <= 1'b0;
      err_warning_flag <= 1'b0;
    end else begin
      bus_off_flag <= tx_err_counter > {1'b0, 8'hFF};
      err_passive_flag <= (tx_err_counter > PASSIVE_LIMIT) || (rx_err_counter > PASSIVE_LIMIT);
      err_warning_flag <= (tx_err_counter > WARN_LIMIT) || (rx_err_counter > WARN_LIMIT);
    end
  end
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      last_error_kind <= LEC_NONE;
    end else if (events.err_valid) begin
      last_error_kind <= events.err_code;
    end else if (events.frame_ok) begin
      last_error_kind <= LEC_NONE;
    end else if (hit(OFS_ERR_STAT)) begin
      last_error_kind <= wbyte[6:4];
    end
  end
  // flag history for rise detection, zero after reset like the flags
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      bus_off_prev <= 1'b0;
      passive_prev <= 1'b0;
      warning_prev <= 1'b0;
    end else begin
      bus_off_prev <= bus_off_flag;
      passive_prev <= err_passive_flag;
      warning_prev <= err_warning_flag;
    end
  end
  assign err_event = (events.err_valid && error_interrupt_enable[4])
    || (bus_off_flag && !bus_off_prev && error_interrupt_enable[2])
    || (err_passive_flag && !passive_prev && error_interrupt_enable[1])
    || (err_warning_flag && !warning_prev && error_interrupt_enable[0]);
  // sticky flags, set wins over clear
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      error_irq_flag <= 1'b0;
      wakeup_flag <= 1'b0;
    end else begin
      error_irq_flag <= err_event
        || (error_irq_flag && !(hit(OFS_MASTER_STAT) && wbyte[MSR_ERROR_IRQ_FLAG_BIT]));
      wakeup_flag <= (events.sof_seen && sleep_mode)
        || (wakeup_flag && !(hit(OFS_MASTER_STAT) && wbyte[MSR_WAKE_BIT]));
    end
  end
  assign status_irq = (wakeup_flag && interrupt_enable[7])
    || (error_irq_flag && error_interrupt_enable[7]);
  assign tx_irq = (request_done_flag != 3'h0) && interrupt_enable[0];
  // ==========================================================
  // read data, captured in the wait cycle
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      readdata <= 32'h0000_0000;
    end else if (read && !ack) begin
      readdata <= 32'h0000_0000;
      case (address)
        OFS_TX_PRIO: readdata[4:0] <= {tx_empty, tx_code};
        OFS_FIFO0: readdata[5:0] <= {release_output_box[0], fifo_overrun_flag[0],
          fifo_full_flag[0], 1'b0, pending_msg_count[0]};
        OFS_FIFO1: readdata[5:0] <= {release_output_box[1], fifo_overrun_flag[1],
          fifo_full_flag[1], 1'b0, pending_msg_count[1]};
        OFS_IRQ_EN: readdata[7:0] <= interrupt_enable;
        OFS_ERR_STAT: readdata[6:0] <= {last_error_kind, 1'b0, bus_off_flag,
          err_passive_flag, err_warning_flag};
        OFS_ERR_IRQ_EN: readdata[7:0] <= error_interrupt_enable;
        OFS_TX_ERR: readdata[7:0] <= tx_err_counter[7:0];
        OFS_RX_ERR: readdata[7:0] <= rx_err_counter[7:0];
        OFS_DIAG: readdata[3:0] <= {rx_pipe[1], sample_bit, diag_modes};
        OFS_BT_PRESCALE: readdata[7:0] <= config_mode ? bit_timing_prescale : 8'h00;
        OFS_BT_SEGMENTS: readdata[6:0] <= bit_timing_segments;
        OFS_MASTER_STAT: readdata[3:2] <= {wakeup_flag, error_irq_flag};
        OFS_TX_STAT: readdata[2:0] <= request_done_flag;
        default: readdata <= 32'h0000_0000;
      endcase
    end
  end
  // ==========================================================
  // assertions
  sequence s_store_into_two(int n);
    events.rx_store[n] && !release_output_box[n] && pending_msg_count[n] == 2'h2;
  endsequence
  property p_wait_one;
    @(posedge clk) disable iff (!rst_sync_n) $rose(read || write) |-> waitrequest ##1 !waitrequest;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("slave did not answer in one wait");
  property p_code_free;
    @(posedge clk) disable iff (!rst_sync_n) tx_empty[0] |-> tx_code == 2'h0;
  endproperty
  a_code_free: assert property (p_code_free) else $error("code not first free mailbox");
  property p_full_set;
    @(posedge clk) disable iff (!rst_sync_n) s_store_into_two(0) |=> fifo_full_flag[0]
      && pending_msg_count[0] == 2'h3;
  endproperty
  a_full_set: assert property (p_full_set) else $error("full flag missed at three");
  property p_overrun;
    @(posedge clk) disable iff (!rst_sync_n) events.rx_store[0] && pending_msg_count[0] == 2'h3
      |=> fifo_overrun_flag[0] && pending_msg_count[0] != 2'h0;
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun flag not set");
  property p_release_empty;
    @(posedge clk) disable iff (!rst_sync_n) pending_msg_count[0] == 2'h0 |=> !release_output_box[0];
  endproperty
  a_release_empty: assert property (p_release_empty) else $error("release on empty fifo");
  property p_release_dec;
    @(posedge clk) disable iff (!rst_sync_n) release_output_box[0] && !events.rx_store[0]
      |=> pending_msg_count[0] == $past(pending_msg_count[0]) - 2'h1 && !release_output_box[0];
  endproperty
  a_release_dec: assert property (p_release_dec) else $error("release did not decrement");
  property p_bus_off;
    @(posedge clk) disable iff (!rst_sync_n) tx_err_counter[8] |=> bus_off_flag;
  endproperty
  a_bus_off: assert property (p_bus_off) else $error("bus-off flag missing");
  property p_passive;
    @(posedge clk) disable iff (!rst_sync_n) rx_err_counter > PASSIVE_LIMIT |=> err_passive_flag;
  endproperty
  a_passive: assert property (p_passive) else $error("error-passive flag missing");
  property p_lec_clean;
    @(posedge clk) disable iff (!rst_sync_n) events.frame_ok && !events.err_valid
      |=> last_error_kind == LEC_NONE;
  endproperty
  a_lec_clean: assert property (p_lec_clean) else $error("code not cleared on clean frame");
  property p_rec_restart;
    @(posedge clk) disable iff (!rst_sync_n) events.rec_ok && !events.rec_inc1 && !events.rec_inc8
      && !events.bus_off_recover && rx_err_counter > REC_HIGH_LIMIT |=> rx_err_counter == REC_RESTART;
  endproperty
  a_rec_restart: assert property (p_rec_restart) else $error("receive counter not set to 120");
  property p_error_irq_flag_bus_off_flag;
    @(posedge clk) disable iff (!rst_sync_n) $rose(bus_off_flag) && error_interrupt_enable[2]
      |=> error_irq_flag;
  endproperty
  a_error_irq_flag_bus_off_flag: assert property (p_error_irq_flag_bus_off_flag) else $error("bus-off did not set error flag");
endmodule
`default_nettype wire

// file: can_node_model.sv
// far-side bus node model feeding protocol engine events
`timescale 1ns/100ps
`default_nettype none
module can_node_model
  import can_status_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // command from the bench
  input wire logic [3:0] op,
  input wire logic [2:0] arg,
  input wire logic rx_level,
  // towards the block
  output core_events_t events,
  output logic can_rx,
  output logic sample_bit
);
  // one-cycle event pulse per command
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      events <= '0;
      can_rx <= 1'b1;
      sample_bit <= 1'b1;
    end else begin
      events <= '0;
      can_rx <= rx_level;
      sample_bit <= rx_level;
      case (op)
        4'h1: events.rx_store <= 2'h1 << arg[0];
        4'h2: {events.err_valid, events.err_code} <= {1'b1, arg};
        4'h3: events.frame_ok <= 1'b1;
        4'h4: events.tec_inc8 <= 1'b1;
        4'h5: events.rec_inc8 <= 1'b1;
        4'h6: events.rec_ok <= 1'b1;
        4'h7: events.tx_done <= 3'h1 << arg[1:0];
        4'h8: events.sof_seen <= 1'b1;
        4'h9: events.rec_inc1 <= 1'b1;
        4'hB: events.bus_off_recover <= 1'b1;
        default: events <= '0;
      endcase
    end
  end
endmodule
`default_nettype wire

// file: can_status_error_interrupt_tb.sv
// self-checking bench for the can status and error block
`timescale 1ns/100ps
`default_nettype none
module can_status_error_interrupt_tb;
  import can_status_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [5:0] address = 6'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata;
  logic waitrequest;
  core_events_t events;
  logic [2:0] tx_pending = 3'h0;
  logic [1:0] tx_lowest = 2'h0;
  logic sleep_mode = 1'b1;
  logic config_mode = 1'b0;
  logic rx_level = 1'b1;
  logic [3:0] op = 4'h0;
  logic [2:0] arg = 3'h0;
  logic sample_bit, can_rx, listen_only_sel, loopback_sel, status_irq, tx_irq;
  bit_timing_t bit_timing;
  logic [1:0] fifo_release, fifo_irq;
  logic [31:0] exp_q[$];
  int checks = 0;
  int mismatches = 0;
  int cycles = 0;
  int releases = 0;
  can_status_error_interrupt can_status_error_interrupt_inst (.clk, .rstn, .address,
    .read, .write, .writedata, .byteenable(4'hF), .readdata, .waitrequest, .events,
    .tx_pending, .tx_lowest, .sleep_mode, .config_mode, .sample_bit, .can_rx,
    .bit_timing, .listen_only_sel, .loopback_sel, .fifo_release, .status_irq,
    .tx_irq, .fifo_irq);
  can_node_model can_node_model_inst (.clk, .rstn, .op, .arg, .rx_level, .events,
    .can_rx, .sample_bit);
  // 100 MHz clock
  initial begin
    forever #5 clk = ~clk;
  end
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      mismatches++;
      $display("Error %s expected %0h seen %0h", n, e, s);
    end
  endtask
  // held request until waitrequest low, then two idle cycles
  task automatic bus(input logic [5:0] a, input logic w, input logic [7:0] d);
    @(posedge clk);
    {address, read, write, writedata} <= {a, !w, w, 24'h0, d};
    do @(posedge clk); while (waitrequest);
    {read, write} <= 2'b00;
    repeat (2) @(posedge clk);
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    bus(a, 1'b1, d);
  endtask
  task automatic rd(input logic [5:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(a, 1'b0, 8'h00);
  endtask
  // one event pulse, then wait until the error interrupt flag settles
  task automatic ev(input logic [3:0] o, input int a);
    @(posedge clk);
    {op, arg} <= {o, 3'(a)};
    @(posedge clk);
    op <= 4'h0;
    repeat (4) @(posedge clk);
  endtask
  // read data checked in the cycle it is accepted
  always @(posedge clk) begin
    if (read && !waitrequest && exp_q.size() > 0) begin
      chk("readdata", readdata, exp_q.pop_front());
    end
  end
  // hang guard
  always @(posedge clk) begin
    cycles++;
    if (fifo_release[0]) begin
      releases++;
    end
    if (cycles == 20000) begin
      mismatches++;
      close_out();
    end
  end
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    logic [2:0] p;
    logic [1:0] c;
    logic [1:0] lo;
    logic [7:0] r;
    r = 8'($urandom(32'hB08A7B9F));
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    rd(OFS_BT_SEGMENTS, 32'h23);
    rd(6'h3C, 32'h0);
    for (int i = 0; i < 6; i++) begin
      p = (i == 5) ? 3'h7 : 3'($urandom);
      lo = 2'($urandom_range(2));
      c = (p == 3'h7) ? lo : (!p[0] ? 2'h0 : (!p[1] ? 2'h1 : 2'h2));
      tx_pending <= p;
      tx_lowest <= lo;
      rd(OFS_TX_PRIO, {27'h0, ~p, c});
    end
    $display("test 1 done");
    wr(OFS_IRQ_EN, 8'h0E);
    ev(4'h1, 0);
    chk("fifo_irq", 32'(fifo_irq), 32'h1);
    ev(4'h1, 0);
    ev(4'h1, 0);
    rd(OFS_FIFO0, 32'h0B);
    ev(4'h1, 0);
    rd(OFS_FIFO0, 32'h1B);
    wr(OFS_FIFO0, 8'h20);
    rd(OFS_FIFO0, 32'h1A);
    wr(OFS_FIFO0, 8'h18);
    rd(OFS_FIFO0, 32'h02);
    wr(OFS_FIFO1, 8'h20);
    rd(OFS_FIFO1, 32'h00);
    chk("fifo_release", 32'(releases), 32'h1);
    $display("test 2 done");
    wr(OFS_ERR_IRQ_EN, 8'h90);
    repeat (16) ev(4'h5, 0);
    rd(OFS_RX_ERR, 32'h80);
    rd(OFS_ERR_STAT, 32'h03);
    ev(4'h6, 0);
    rd(OFS_ERR_STAT, 32'h01);
    ev(4'h5, 0);
    ev(4'h6, 0);
    ev(4'h9, 0);
    rd(OFS_RX_ERR, 32'h79);
    for (int i = 1; i < 7; i++) begin
      ev(4'h2, i);
      rd(OFS_ERR_STAT, 32'(i * 16 + 1));
    end
    chk("status_irq", 32'(status_irq), 32'h1);
    ev(4'h3, 0);
    wr(OFS_MASTER_STAT, 8'h04);
    rd(OFS_ERR_STAT, 32'h01);
    wr(OFS_ERR_STAT, 8'h70);
    rd(OFS_ERR_STAT, 32'h71);
    chk("status_irq", 32'(status_irq), 32'h0);
    wr(OFS_ERR_IRQ_EN, 8'h84);
    repeat (32) ev(4'h4, 0);
    rd(OFS_TX_ERR, 32'h00);
    rd(OFS_ERR_STAT, 32'h77);
    chk("status_irq", 32'(status_irq), 32'h1);
    ev(4'hB, 0);
    rd(OFS_ERR_STAT, 32'h70);
    $display("test 3 done");
    wr(OFS_MASTER_STAT, 8'h04);
    wr(OFS_IRQ_EN, 8'h81);
    ev(4'h8, 0);
    rd(OFS_MASTER_STAT, 32'h08);
    chk("status_irq", 32'(status_irq), 32'h1);
    ev(4'h7, 2);
    chk("tx_irq", 32'(tx_irq), 32'h1);
    rd(OFS_TX_STAT, 32'h04);
    wr(OFS_TX_STAT, 8'h04);
    rd(OFS_TX_STAT, 32'h00);
    wr(OFS_DIAG, r);
    rd(OFS_DIAG, 32'(r[1:0]) | 32'h0C);
    chk("listen_only_sel", 32'(listen_only_sel), 32'(r[1]));
    chk("loopback_sel", 32'(loopback_sel), 32'(r[0]));
    wr(OFS_BT_PRESCALE, r);
    config_mode <= 1'b1;
    rd(OFS_BT_PRESCALE, 32'h00);
    wr(OFS_BT_PRESCALE, r);
    rd(OFS_BT_PRESCALE, 32'(r));
    chk("bit_timing", 32'(bit_timing[14:7]), 32'(r));
    $display("test 4 done");
    close_out();
  end
endmodule
`default_nettype wire
